// ==== rtl/rotor_angle_pkg.sv ====
// register map, field positions, reset values and tables for the rotor angle feedback block
// assumes a 32-bit avalon-mm slave with byte addresses and one aligned word per register
package rotor_angle_pkg;

  // widths
  localparam int POS_W = 24;
  localparam int NPP_W = 8;
  localparam int ANG_W = 16;
  localparam int ADDR_W = 5;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_REV_LEN = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_NPP = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_OFFSET = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_POSITION = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_ANGLE = 5'h18;

  // control register bits
  localparam int CTRL_DIR_INVERT = 0;
  localparam int CTRL_HALL_ARM = 1;
  localparam int CTRL_HALL_SOURCE = 2;
  localparam int CTRL_CLEAR_POS = 3;

  // status register bits
  localparam int STAT_HALL_LSB = 0;
  localparam int STAT_INIT_DONE = 4;
  localparam int STAT_HALL_BAD = 5;
  localparam int STAT_SECTOR_LSB = 8;

  // reset values
  localparam logic [POS_W-1:0] REV_LEN_RESET = 24'h001000;
  localparam logic [NPP_W-1:0] NPP_RESET = 8'h01;
  localparam logic [ANG_W-1:0] OFFSET_RESET = 16'h0000;

  // one sixty degree step of a full electrical turn of 2^16
  localparam logic [ANG_W-1:0] ANGLE_60 = 16'h2aab;
  localparam logic [4:0] DIV_STEPS = 5'h10;

  // hall code to sector; code 0 and 7 are invalid and report sector 7
  function automatic logic [2:0] hall_sector(input logic [2:0] code);
    case (code)
      3'h1: hall_sector = 3'h0;
      3'h3: hall_sector = 3'h1;
      3'h2: hall_sector = 3'h2;
      3'h6: hall_sector = 3'h3;
      3'h4: hall_sector = 3'h4;
      3'h5: hall_sector = 3'h5;
      default: hall_sector = 3'h7;
    endcase
  endfunction : hall_sector

endpackage : rotor_angle_pkg

// ==== rtl/rotor_angle_feedback_init.sv ====
// rotor angle feedback: quadrature encoder and digital hall sensors to electrical angle
// assumes enc_a, enc_b and hall pins are asynchronous; registers on avalon-mm with waitrequest
//
// Functional notes
// R1: programmable encoder count direction
// R2: software sets direction matching field rotation
// R3: hall states give sixty degree absolute sectors
// R4: hall init loads encoder at first hall edge
// R5: electrical angle scaled by pole pair count
// R6: resolution counted in quadrature positions per revolution
// R7: software forces alignment current before referencing
// R8: offset adjusted live during minimum movement init
// R9: angle from position sensors only
// R10: preset absolute encoder needs no init
// R11: hall coarse start, encoder fine afterwards
// R12: offset added, wrapped modulo one electrical turn
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module rotor_angle_feedback_init #(
  parameter int POS_W = rotor_angle_pkg::POS_W,
  parameter int NPP_W = rotor_angle_pkg::NPP_W,
  parameter int ANG_W = rotor_angle_pkg::ANG_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [rotor_angle_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [2:0] hall_in,
  output logic [ANG_W-1:0] elec_angle
);

  typedef struct packed {
    logic [2:0] a_sync;
    logic [2:0] b_sync;
    logic [2:0][2:0] h_sync;
    logic dir_invert;
    logic hall_armed;
    logic hall_source;
    logic init_done;
    logic [1:0] warm;
    logic [POS_W-1:0] rev_len;
    logic [NPP_W-1:0] npp;
    logic [ANG_W-1:0] offset;
    logic [POS_W-1:0] mech_pos;
    logic [POS_W-1:0] elec_pos;
    logic [POS_W:0] div_rem;
    logic [ANG_W-1:0] div_quo;
    logic [4:0] div_cnt;
    logic [ANG_W-1:0] enc_angle;
    logic [ANG_W-1:0] angle;
    logic [31:0] rdata;
    logic waitreq;
  } state_t;

  state_t s_q;
  state_t s_d;

  // combinational helpers
  logic [1:0] ab_old;
  logic [1:0] ab_new;
  logic step_up;
  logic step_dn;
  logic [2:0] hall_now;
  logic [2:0] sector;
  logic [ANG_W-1:0] hall_angle;
  logic [POS_W+ANG_W-1:0] hall_prod;
  logic [POS_W:0] rem_sh;
  logic access;
  logic [31:0] wmask;

  // next-state logic for the whole block
  always_comb
  begin
    s_d = s_q;
    // three-stage synchronisers; stage 1 feeds stage 2 only
    s_d.a_sync = {s_q.a_sync[1:0], enc_a};
    s_d.b_sync = {s_q.b_sync[1:0], enc_b};
    s_d.h_sync = {s_q.h_sync[1:0], hall_in};

    // quadrature decode from stage 3 (old) to stage 2 (new), four counts per line
    ab_old = {s_q.a_sync[2], s_q.b_sync[2]};
    ab_new = {s_q.a_sync[1], s_q.b_sync[1]};
    step_up = 1'b0;
    step_dn = 1'b0;
    case ({ab_old, ab_new})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: step_up = 1'b1; // R6
      4'b0010, 4'b1011, 4'b1101, 4'b0100: step_dn = 1'b1; // R6
      default: ;
    endcase
    if (s_q.dir_invert) // R1
    begin
      {step_up, step_dn} = {step_dn, step_up};
    end
    // no decoding until all three stages hold real pin samples; avoids a false step after reset
    s_d.warm = s_q.warm + {1'b0, ~&s_q.warm};
    if (!(&s_q.warm))
    begin
      step_up = 1'b0;
      step_dn = 1'b0;
    end

    // mechanical position wraps within positions_per_revolution
    if (step_up)
    begin
      s_d.mech_pos = (s_q.mech_pos >= s_q.rev_len - 1'b1) ? '0 : s_q.mech_pos + 1'b1; // R6
    end
    else if (step_dn)
    begin
      s_d.mech_pos = (s_q.mech_pos == '0) ? s_q.rev_len - 1'b1 : s_q.mech_pos - 1'b1;
    end

    // electrical position steps by pole pairs modulo positions_per_revolution
    if (step_up)
    begin
      s_d.elec_pos = (s_q.elec_pos + POS_W'(s_q.npp) >= s_q.rev_len) ?
                     s_q.elec_pos + POS_W'(s_q.npp) - s_q.rev_len : s_q.elec_pos + POS_W'(s_q.npp); // R5
    end
    else if (step_dn)
    begin
      s_d.elec_pos = (s_q.elec_pos < POS_W'(s_q.npp)) ?
                     s_q.elec_pos + s_q.rev_len - POS_W'(s_q.npp) : s_q.elec_pos - POS_W'(s_q.npp); // R5
    end

    // hall sector to absolute angle in sixty degree steps
    hall_now = s_q.h_sync[1];
    sector = rotor_angle_pkg::hall_sector(hall_now);
    hall_angle = ANG_W'(sector) * rotor_angle_pkg::ANGLE_60; // R3
    hall_prod = hall_angle * s_q.rev_len;

    // first valid hall edge while armed loads the encoder reference
    if (s_q.hall_armed && (&s_q.warm) && (hall_now != s_q.h_sync[2]) && (sector != 3'h7)) // R4
    begin
      s_d.elec_pos = hall_prod[POS_W+ANG_W-1:ANG_W]; // R11
      s_d.hall_armed = 1'b0;
      s_d.init_done = 1'b1;
    end

    // serial divider: angle = elec_pos * 2^16 / positions_per_revolution
    rem_sh = {s_q.div_rem[POS_W-1:0], 1'b0};
    if (s_q.div_cnt == '0)
    begin
      s_d.enc_angle = s_q.div_quo;
      s_d.div_rem = {1'b0, s_q.elec_pos};
      s_d.div_cnt = rotor_angle_pkg::DIV_STEPS;
    end
    else
    begin
      if (rem_sh >= {1'b0, s_q.rev_len})
      begin
        s_d.div_rem = rem_sh - {1'b0, s_q.rev_len};
        s_d.div_quo = {s_q.div_quo[ANG_W-2:0], 1'b1}; // R5
      end
      else
      begin
        s_d.div_rem = rem_sh;
        s_d.div_quo = {s_q.div_quo[ANG_W-2:0], 1'b0};
      end
      s_d.div_cnt = s_q.div_cnt - 1'b1;
    end

    // output angle: sensor angle plus offset, wrapping at one electrical turn
    s_d.angle = (s_q.hall_source ? hall_angle : s_q.enc_angle) + s_q.offset; // R12 R9 R8

    // avalon-mm slave: one wait cycle, then answer with waitrequest low
    access = (avs_read || avs_write) && s_q.waitreq;
    s_d.waitreq = !access;
    s_d.rdata = '0;
    for (int i = 0; i < 4; i++)
    begin
      wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
    // a write lands at the edge where the master sees waitrequest low
    if (avs_write && !s_q.waitreq)
    begin
      case (avs_address)
        rotor_angle_pkg::OFS_CTRL:
        begin
          if (avs_byteenable[0])
          begin
            s_d.dir_invert = avs_writedata[rotor_angle_pkg::CTRL_DIR_INVERT]; // R1
            s_d.hall_source = avs_writedata[rotor_angle_pkg::CTRL_HALL_SOURCE];
            if (avs_writedata[rotor_angle_pkg::CTRL_HALL_ARM])
            begin
              s_d.hall_armed = 1'b1;
              s_d.init_done = 1'b0;
            end
            if (avs_writedata[rotor_angle_pkg::CTRL_CLEAR_POS])
            begin
              s_d.mech_pos = '0;
              s_d.elec_pos = '0;
            end
          end
        end
        rotor_angle_pkg::OFS_REV_LEN:
          s_d.rev_len = (s_q.rev_len & ~wmask[POS_W-1:0]) | (avs_writedata[POS_W-1:0] & wmask[POS_W-1:0]);
        rotor_angle_pkg::OFS_NPP:
          s_d.npp = (s_q.npp & ~wmask[NPP_W-1:0]) | (avs_writedata[NPP_W-1:0] & wmask[NPP_W-1:0]);
        rotor_angle_pkg::OFS_OFFSET: // R8
          s_d.offset = (s_q.offset & ~wmask[ANG_W-1:0]) | (avs_writedata[ANG_W-1:0] & wmask[ANG_W-1:0]);
        default: ;
      endcase
    end
    else if (access && avs_read)
    begin
      case (avs_address)
        rotor_angle_pkg::OFS_CTRL:
        begin
          s_d.rdata[rotor_angle_pkg::CTRL_DIR_INVERT] = s_q.dir_invert;
          s_d.rdata[rotor_angle_pkg::CTRL_HALL_ARM] = s_q.hall_armed;
          s_d.rdata[rotor_angle_pkg::CTRL_HALL_SOURCE] = s_q.hall_source;
        end
        rotor_angle_pkg::OFS_REV_LEN: s_d.rdata[POS_W-1:0] = s_q.rev_len;
        rotor_angle_pkg::OFS_NPP: s_d.rdata[NPP_W-1:0] = s_q.npp;
        rotor_angle_pkg::OFS_OFFSET: s_d.rdata[ANG_W-1:0] = s_q.offset;
        rotor_angle_pkg::OFS_STATUS:
        begin
          s_d.rdata[rotor_angle_pkg::STAT_HALL_LSB +: 3] = hall_now;
          s_d.rdata[rotor_angle_pkg::STAT_INIT_DONE] = s_q.init_done;
          s_d.rdata[rotor_angle_pkg::STAT_HALL_BAD] = (sector == 3'h7);
          s_d.rdata[rotor_angle_pkg::STAT_SECTOR_LSB +: 3] = sector;
        end
        rotor_angle_pkg::OFS_POSITION: s_d.rdata[POS_W-1:0] = s_q.mech_pos;
        rotor_angle_pkg::OFS_ANGLE: s_d.rdata[ANG_W-1:0] = s_q.angle;
        default: ;
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.rev_len <= rotor_angle_pkg::REV_LEN_RESET;
      s_q.npp <= rotor_angle_pkg::NPP_RESET;
      s_q.offset <= rotor_angle_pkg::OFFSET_RESET;
      s_q.waitreq <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign elec_angle = s_q.angle;

endmodule : rotor_angle_feedback_init

`default_nettype wire

// ==== bench/rotor_angle_feedback_init_sva.sv ====
// checker for the bus handshake, register reads and electrical angle
// bound into the top module; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module rotor_angle_feedback_init_sva #(
  parameter int ANG_W = rotor_angle_pkg::ANG_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [rotor_angle_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [2:0] hall_in,
  input wire logic [ANG_W-1:0] elec_angle
);
  logic [5:0] quiet_q;
  logic [4:0] pins_q;
  // cycles since the last sensor change or register write
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quiet_q <= 6'h0;
      pins_q <= 5'h0;
    end
    else
    begin
      quiet_q <= ({enc_a, enc_b, hall_in} != pins_q || avs_write) ? 6'h0 : quiet_q + {5'h0, quiet_q != 6'h3f};
      pins_q <= {enc_a, enc_b, hall_in};
    end
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // handshake and read data shape
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  chk_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  chk_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data outside answer");
  chk_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address > 5'h18 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_angle_read: assert property (avs_read && avs_waitrequest && avs_address == rotor_angle_pkg::OFS_ANGLE
    |=> avs_readdata == 32'($past(elec_angle))) else $error("angle read differs");
  // angle moves only after a sensor change or a register write; the serial divider may need up to 37 cycles to follow
  chk_angle_still: assert property (quiet_q >= 6'h28 |-> $stable(elec_angle))
    else $error("angle moved with sensors still");
  chk_status_hall: assert property (avs_read && avs_waitrequest && avs_address == rotor_angle_pkg::OFS_STATUS &&
    quiet_q > 6'h8 |=> avs_readdata[2:0] == $past(hall_in) && avs_readdata[31:11] == 21'h0)
    else $error("status hall field wrong");
endmodule : rotor_angle_feedback_init_sva
bind rotor_angle_feedback_init rotor_angle_feedback_init_sva #(.ANG_W(ANG_W)) sva_u (.clk_sys(clk_sys),
  .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .enc_a(enc_a), .enc_b(enc_b),
  .hall_in(hall_in), .elec_angle(elec_angle));
`default_nettype wire

// ==== bench/motor_sensor_model.sv ====
// motor side: quadrature encoder lines and three digital hall outputs
// steps and hall codes come from the bench, one step per clock asked
`timescale 1ns/1ps
`default_nettype none
module motor_sensor_model (
  input wire logic clk_sys,
  input wire logic step,
  input wire logic fwd,
  input wire logic [2:0] hall_cmd,
  output logic enc_a,
  output logic enc_b,
  output logic [2:0] hall_in
);
  logic [1:0] ph_q = 2'h0;
  logic [2:0] hall_q = 3'h1;
  // positive turn walks the gray cycle up, four states per line
  always @(posedge clk_sys)
  begin
    if (step)
      ph_q <= fwd ? ph_q + 2'h1 : ph_q - 2'h1;
    hall_q <= hall_cmd;
  end
  assign enc_a = ph_q[1];
  assign enc_b = ph_q[1] ^ ph_q[0];
  assign hall_in = hall_q;
endmodule : motor_sensor_model
`default_nettype wire

// ==== bench/rotor_angle_feedback_init_tb.sv ====
// self-checking bench: registers, encoder count, hall init, hall sectors
// drives avalon-mm and the motor model; one 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
module rotor_angle_feedback_init_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic step = 1'b0;
  logic [4:0] avs_address = 5'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [2:0] hall_cmd = 3'h1;
  logic avs_waitrequest, enc_a, enc_b;
  logic [2:0] hall_in;
  logic [15:0] elec_angle;
  logic [31:0] avs_readdata, rd;
  int err_count = 0, samples_checked = 0, o, k;
  logic [4:0] ra [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h14, 5'h18, 5'h1c};
  logic [31:0] rv [7] = '{0, 32'h1000, 1, 0, 0, 0, 0};
  logic [2:0] codes [7] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5, 3'h7};
  always #10 clk_sys = ~clk_sys;
  rotor_angle_feedback_init dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .enc_a(enc_a), .enc_b(enc_b),
    .hall_in(hall_in), .elec_angle(elec_angle));
  motor_sensor_model mot_u (.clk_sys(clk_sys), .step(step), .fwd(1'b1), .hall_cmd(hall_cmd), .enc_a(enc_a),
    .enc_b(enc_b), .hall_in(hall_in));
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge clk_sys);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // encoder steps, then time for the angle to settle
  task automatic steps(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      step <= 1'b1;
      @(posedge clk_sys);
      step <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    repeat (40) @(posedge clk_sys);
  endtask : steps
  function automatic logic [31:0] ea(input int ep, input int rev, input int off);
    return ((ep % rev) * 65536 / rev + off) % 65536;
  endfunction : ea
  initial
  begin
    #200us;
    err_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    stop_test();
  end
  initial
  begin
    void'($urandom(32'h075abbbb));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b1, 5'h1c, 32'hffffffff);
    foreach (ra[i])
    begin
      bus(1'b0, ra[i], 0);
      cmp(rd, rv[i]);
    end
    o = $urandom % 65536;
    bus(1'b1, 5'h0c, o);
    bus(1'b1, 5'h08, 4);
    bus(1'b1, 5'h04, 400);
    k = $urandom_range(25, 5);
    steps(k);
    bus(1'b0, 5'h14, 0);
    cmp(rd, k);
    cmp({16'h0, elec_angle}, ea(k * 4, 400, o));
    bus(1'b1, 5'h00, 32'h9);
    steps(3);
    bus(1'b0, 5'h14, 0);
    cmp(rd, 397);
    cmp({16'h0, elec_angle}, ea(397 * 4, 400, o));
    bus(1'b1, 5'h00, 32'h2);
    hall_cmd <= 3'h3;
    steps(0);
    bus(1'b0, 5'h10, 0);
    cmp(rd & 32'h737, 32'h113);
    cmp({16'h0, elec_angle}, ea(66, 400, o));
    steps(2);
    cmp({16'h0, elec_angle}, ea(74, 400, o));
    bus(1'b1, 5'h0c, 0);
    bus(1'b1, 5'h00, 32'h4);
    foreach (codes[i])
    begin
      hall_cmd <= codes[i];
      steps(0);
      bus(1'b0, 5'h10, 0);
      cmp(rd & 32'h727, ((i < 6 ? i : 7) << 8) | ((i == 6) << 5) | codes[i]);
      if (i < 6)
        cmp({16'h0, elec_angle}, rotor_angle_pkg::ANGLE_60 * i);
    end
    stop_test();
  end
endmodule : rotor_angle_feedback_init_tb
`default_nettype wire
